// ### verification/fhd_ctrl_props.sv
// port checker for the disc controller
`timescale 1ns/100ps
`default_nettype none
module fhd_ctrl_props
  import fhd_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // instructions
  input wire logic cmd_strobe_i,
  input wire logic [15:0] cmd_word_i,
  input wire logic test_strobe_i,
  input wire logic [15:0] test_word_i,
  input wire logic skip_o,
  input wire logic skip_valid_o,
  input wire logic btc_init_o,
  // host side
  input wire logic host_wr_request_o,
  input wire logic pi1_o,
  input wire logic pi2_o,
  input wire logic reg_re_i,
  input wire logic [31:0] reg_rdata_o,
  // disc side
  input wire logic [8:0] disc_track_o,
  input wire logic [3:0] disc_sector_o,
  input wire logic disc_write_o,
  input wire logic disc_read_o,
  input wire logic disc_word_o
);
  // --
  // helper logic
  // --
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  logic busy; // transfer running
  logic [9:0] gap_cnt; // cycles since last word slot
  logic [9:0] next_gap_cnt;
  assign busy = disc_write_o | disc_read_o;
  // saturating slot distance counter
  always_comb begin
    next_gap_cnt = gap_cnt;
    if (reset_i) begin
      next_gap_cnt = 10'h3FF;
    end else if (disc_word_o) begin
      next_gap_cnt = 10'h000;
    end else if (gap_cnt != 10'h3FF) begin
      next_gap_cnt = gap_cnt + 10'h001;
    end
  end
  always_ff @(posedge clk_i) begin
    gap_cnt <= next_gap_cnt;
  end
  // --
  // assertions
  // --
  a_skip_answer: assert property (test_strobe_i |=> skip_valid_o) else $error("no skip answer");
  a_skip_alone: assert property (skip_valid_o |-> $past(test_strobe_i)) else $error("stray skip");
  a_busy_noskip: assert property (
    test_strobe_i && test_word_i[15:9] == 7'h01 && busy |=> !skip_o) else $error("skip while busy");
  a_btc_pulse: assert property (
    cmd_strobe_i && (cmd_word_i[15] || cmd_word_i[2]) |=> btc_init_o) else $error("no channel init");
  a_track_load: assert property (
    cmd_strobe_i && cmd_word_i[1:0] == CMD_TYPE_SELECT && !busy |=> disc_track_o == $past(cmd_word_i[11:3]))
    else $error("track not loaded");
  a_write_start: assert property (
    cmd_strobe_i && cmd_word_i[1:0] == CMD_TYPE_WRITE && !busy
    |=> disc_write_o && !disc_read_o && disc_sector_o == $past(cmd_word_i[6:3])) else $error("write not started");
  a_read_start: assert property (
    cmd_strobe_i && cmd_word_i[1:0] == CMD_TYPE_READ && !busy |=> disc_read_o && !disc_write_o)
    else $error("read not started");
  a_one_way: assert property (!(disc_write_o && disc_read_o)) else $error("both directions");
  a_pi1_off: assert property (
    cmd_strobe_i && cmd_word_i[13] && !cmd_word_i[14] |=> !pi1_o) else $error("pi1 not disabled");
  a_pi2_off: assert property (
    cmd_strobe_i && cmd_word_i[12] && !cmd_word_i[14] |=> !pi2_o) else $error("pi2 not disabled");
  a_word_spacing: assert property (disc_word_o |-> gap_cnt >= 10'h0B0) else $error("slots too close");
  a_wr_request: assert property (host_wr_request_o |-> disc_write_o) else $error("request idle");
  a_rdata_quiet: assert property (!reg_re_i |=> reg_rdata_o == 32'h0) else $error("read data stray");
  c_write_word: cover property (disc_word_o && disc_write_o);
  c_skip_none: cover property (skip_valid_o && !skip_o);
  c_pi2_rise: cover property ($rose(pi2_o));
endmodule
`default_nettype wire

// ### verification/fhd_ctrl_tb_top.sv
// self-checking bench for the disc controller
`timescale 1ns/100ps
`default_nettype none
module fhd_ctrl_tb_top;
  import fhd_pkg::*;
  // --
  // signals
  // --
  logic clk_i, reset_i, cmd_strobe_i, test_strobe_i, host_wr_strobe_i, host_rd_strobe_i;
  logic reg_we_i, reg_re_i, disc_online_i, disc_protect_i;
  logic [15:0] cmd_word_i, test_word_i, host_wr_data_i, host_rd_data_o, disc_rd_data_i, disc_wr_data_o;
  logic [3:0] reg_addr_i, disc_sector_o;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [8:0] disc_track_o;
  logic skip_o, skip_valid_o, btc_init_o, host_rd_avail_o, host_wr_request_o, pi1_o, pi2_o, irq_o;
  logic disc_write_o, disc_read_o, disc_word_o;
  int miscompares = 0;
  int total_checks = 0;
  int i;
  logic [15:0] sum; // sum of words handed over
  fhd_ctrl DUT (.*);
  fhd_disc_model disc_model (.clk_i, .reset_i, .sector_i(disc_sector_o), .write_i(disc_write_o),
    .read_i(disc_read_o), .word_i(disc_word_o), .wr_data_i(disc_wr_data_o), .rd_data_o(disc_rd_data_i));
  // 50 ns clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // --
  // tasks
  // --
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // word pattern, word 3 is lost on the late write
  function automatic logic [15:0] exp_w(input int k);
    return (k == 3) ? 16'h0000 : {4'hC, k[11:0]};
  endfunction
  function automatic logic sig(input int k);
    case (k)
      0: return host_wr_request_o;
      1: return host_rd_avail_o;
      2: return disc_word_o;
      default: return !(disc_write_o || disc_read_o);
    endcase
  endfunction
  // bounded wait on a design flag
  task automatic wait_sig(input int k, input int lim);
    int n;
    n = 0;
    while (sig(k) !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= lim) begin
      miscompares++;
      $display("[FAIL] %0t wait ran out", $time);
      complete_run();
    end
  endtask
  task automatic cmd(input logic [15:0] w);
    @(posedge clk_i);
    cmd_strobe_i <= 1'b1;
    cmd_word_i <= w;
    @(posedge clk_i);
    cmd_strobe_i <= 1'b0;
    #1;
  endtask
  // b is the documented test bit number
  task automatic test(input int b, input logic exp);
    @(posedge clk_i);
    test_strobe_i <= 1'b1;
    test_word_i <= 16'h8000 >> b;
    @(posedge clk_i);
    test_strobe_i <= 1'b0;
    #1;
    check(skip_valid_o, 1'b1);
    check(skip_o, exp);
  endtask
  task automatic reg_io(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_we_i <= wr;
    reg_re_i <= !wr;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
    reg_re_i <= 1'b0;
    #1;
    if (!wr)
      check(reg_rdata_o, d);
  endtask
  task automatic xfer(input logic wr, input logic [15:0] d, input logic cmp);
    @(posedge clk_i);
    host_wr_strobe_i <= wr;
    host_rd_strobe_i <= !wr;
    host_wr_data_i <= d;
    @(posedge clk_i);
    host_wr_strobe_i <= 1'b0;
    host_rd_strobe_i <= 1'b0;
    #1;
    if (cmp)
      check(host_rd_data_o, d);
  endtask
  // one sector of host words, the word at late misses its slot
  task automatic run_sector(input logic wr, input int late);
    i = 0;
    sum = 16'h0000;
    while (i < 111) begin
      wait_sig(wr ? 0 : 1, 400);
      if (wr && i == 1)
        cmd(16'h0003);
      if (i == late) begin
        @(posedge clk_i);
        #1;
        wait_sig(2, 400);
        if (!wr)
          xfer(1'b0, 16'h0000, 1'b0);
        i = i + (wr ? 1 : 2);
      end else begin
        xfer(wr, exp_w(i), !wr);
        sum = sum + exp_w(i);
        i++;
      end
    end
  endtask
  // --
  // main sequence
  // --
  initial begin
    {reset_i, disc_online_i} = 2'h3;
    {cmd_strobe_i, test_strobe_i, host_wr_strobe_i, host_rd_strobe_i, reg_we_i, reg_re_i, disc_protect_i} = 7'h00;
    {cmd_word_i, test_word_i, host_wr_data_i, reg_addr_i, reg_wdata_i} = 84'h0;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
    check({pi1_o, pi2_o, irq_o, disc_write_o, disc_read_o, btc_init_o, skip_valid_o, host_wr_request_o}, 0);
    repeat (6) @(posedge clk_i);
    #1;
    for (i = 0; i < 7; i++) test(i, 1'b1);
    @(posedge clk_i);
    disc_online_i <= 1'b0;
    disc_protect_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    #1;
    test(1, 1'b0);
    test(5, 1'b0);
    disc_online_i <= 1'b1;
    disc_protect_i <= 1'b0;
    cmd(16'h6000);
    test(0, 1'b0);
    check(pi1_o, 1'b1);
    cmd(16'h2000);
    reg_io(1'b1, REG_ENABLE, 32'h1);
    reg_io(1'b0, REG_STATUS, 32'h1);
    check(irq_o, 1'b1);
    check(pi1_o, 1'b0);
    reg_io(1'b0, 4'h2, 32'h0);
    reg_io(1'b1, REG_STATUS, 32'h0);
    reg_io(1'b0, REG_CLEAR, 32'h0);
    reg_io(1'b1, REG_CLEAR, 32'h1F);
    reg_io(1'b0, REG_STATUS, 32'h0);
    check(irq_o, 1'b0);
    cmd(16'h8D2B);
    check(btc_init_o, 1'b1);
    reg_io(1'b0, REG_POSITION, 32'h1A50);
    cmd(16'h587A);
    check({disc_write_o, disc_sector_o}, 5'h1F);
    test(6, 1'b0);
    run_sector(1'b1, 3);
    wait_sig(3, 25000);
    check(disc_track_o, 9'h1A5);
    check(pi2_o, 1'b1);
    check(disc_model.mem[15][111], sum);
    reg_io(1'b0, REG_STATUS, 32'h19);
    reg_io(1'b1, REG_CLEAR, 32'h1F);
    cmd(16'h0079);
    check({disc_read_o, pi2_o}, 2'h2);
    run_sector(1'b0, 5);
    wait_sig(3, 25000);
    test(2, 1'b0);
    test(4, 1'b1);
    check(pi2_o, 1'b1);
    reg_io(1'b0, REG_STATUS, 32'h14);
    complete_run();
  end
endmodule
bind fhd_ctrl fhd_ctrl_props props (.*);
`default_nettype wire

// ### verification/fhd_disc_model.sv
// behavioural fixed-head disc holding one track of sectors
`timescale 1ns/100ps
`default_nettype none
module fhd_disc_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // controller side
  input wire logic [3:0] sector_i,
  input wire logic write_i,
  input wire logic read_i,
  input wire logic word_i,
  input wire logic [15:0] wr_data_i,
  output logic [15:0] rd_data_o
);
  // --
  // sector store, 111 data slots and a checksum slot
  // --
  logic [15:0] mem [16][112];
  logic [6:0] slot; // slot within the sector
  logic [15:0] noise; // toggles while nothing is read
  // step the slot per word pulse, record written words
  always_ff @(posedge clk_i) begin
    noise <= reset_i ? 16'h5A5A : ~noise;
    if (reset_i || !(write_i || read_i)) begin
      slot <= 7'h00;
    end else if (word_i) begin
      if (write_i) begin
        mem[sector_i][slot] <= wr_data_i;
      end
      slot <= (slot == 7'h6F) ? 7'h00 : slot + 7'h01;
    end
  end
  // stored word stands ahead of its slot
  assign rd_data_o = read_i ? mem[sector_i][slot] : noise;
endmodule
`default_nettype wire

// ### verilog/fhd_checksum.sv
// running sector checksum, sixteen-bit modular sum
`timescale 1ns/100ps
`default_nettype none
module fhd_checksum #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // control and data
  input wire logic clear_i,
  input wire logic add_i,
  input wire logic [W-1:0] word_i,
  output logic [W-1:0] sum_o
);
  logic [W-1:0] next_sum;  // sum after this cycle

  // ----------------------------------------------------------------
  // clear wins over add so a sector always starts from zero
  // ----------------------------------------------------------------
  always_comb begin
    next_sum = sum_o;
    if (clear_i) begin
      next_sum = '0;
    end else if (add_i) begin
      next_sum = sum_o + word_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sum_o <= '0;
    end else begin
      sum_o <= next_sum;
    end
  end
endmodule
`default_nettype wire

// ### verilog/fhd_ctrl.sv
// fixed-head disc control unit: commands, tests, interrupts, data words
//
// Functional notes
// RL1 - four command types: track, write, read, sequential; code decodes three, sequential is a bit 4 flag on write/read
// RL2 - seven tests, skip when condition is reset
// RL3 - test bits 0..3 decoded one-hot
// RL4 - test bits 4..6 one-hot, others ignored
// RL5 - two interrupts, enables set only by commands
// RL6 - bit 1 chooses, bits 2,3 pick interrupts
// RL7 - int one errors, int two overflows
// RL8 - bits 14,15 set: nine-bit track number
// RL9 - bit 4 sequential from four-bit start sector
// RL10 - 14 alone writes, 15 alone reads
// RL11 - 111 words per sector, 16 sectors
// RL12 - about 37.2 us gap between sectors
// RL13 - host wires bits 0,13 to channel init
// RL14 - one word per host transfer each way
// RL15 - nine-bit track spans all 512 heads
// RL16 - checksum appended on write, compared on read
// RL17 - late host word flags overflow
`timescale 1ns/100ps
`default_nettype none
module fhd_ctrl
  import fhd_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // command and test instructions
  input wire logic cmd_strobe_i,
  input wire logic [fhd_pkg::WORD_W-1:0] cmd_word_i,
  input wire logic test_strobe_i,
  input wire logic [fhd_pkg::WORD_W-1:0] test_word_i,
  output logic skip_o,
  output logic skip_valid_o,
  output logic btc_init_o,
  // host data transfers
  input wire logic host_wr_strobe_i,
  input wire logic [fhd_pkg::WORD_W-1:0] host_wr_data_i,
  input wire logic host_rd_strobe_i,
  output logic [fhd_pkg::WORD_W-1:0] host_rd_data_o,
  output logic host_rd_avail_o,
  output logic host_wr_request_o,
  // priority interrupts
  output logic pi1_o,
  output logic pi2_o,
  // register port
  input wire logic [fhd_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o,
  // disc storage unit
  input wire logic disc_online_i,
  input wire logic disc_protect_i,
  input wire logic [fhd_pkg::WORD_W-1:0] disc_rd_data_i,
  output logic [fhd_pkg::TRACK_W-1:0] disc_track_o,
  output logic [fhd_pkg::SECTOR_W-1:0] disc_sector_o,
  output logic disc_write_o,
  output logic disc_read_o,
  output logic disc_word_o,
  output logic [fhd_pkg::WORD_W-1:0] disc_wr_data_o
);
  import fhd_pkg::*;

  // --
  // state
  // --
  fhd_state_e state, next_state;                  // sequencer
  logic [7:0] tick_cnt, next_tick_cnt;            // word period divider
  logic [6:0] word_idx, next_word_idx;            // word within sector
  logic [9:0] gap_cnt, next_gap_cnt;              // inter-sector gap
  logic [TRACK_W-1:0] next_track;                 // selected track
  logic [SECTOR_W-1:0] next_sector;               // current sector
  logic seq, next_seq;                            // sequential mode
  logic dir_write, next_dir_write;                // transfer direction
  logic pi1_en, next_pi1_en;                      // interrupt one enable
  logic pi2_en, next_pi2_en;                      // interrupt two enable
  logic [WORD_W-1:0] wbuf, next_wbuf;             // word from host
  logic wbuf_full, next_wbuf_full;
  logic [WORD_W-1:0] rbuf, next_rbuf;             // word for host
  logic rbuf_full, next_rbuf_full;                // host word waiting
  logic [WORD_W-1:0] next_host_rd_data;
  logic [WORD_W-1:0] next_disc_wr_data;
  logic [EV_W-1:0] flags, next_flags;             // sticky events
  logic [EV_W-1:0] irq_en, next_irq_en;           // event enables
  logic [EV_W-1:0] ev;                            // events this cycle
  logic [31:0] next_rdata;
  logic next_skip, next_btc_init, next_disc_word;
  logic cks_clear, cks_add;                       // checksum control
  logic [WORD_W-1:0] cks_word, cks_sum;
  logic online, protect;                          // clean pin levels
  logic busy, word_tick;
  logic [6:0] test_cond;                          // conditions, doc bit 0 first

  // --
  // pin synchronisers and checksum
  // --
  fhd_sync u_sync_online (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(disc_online_i),
    .level_o(online)
  );

  fhd_sync u_sync_protect (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(disc_protect_i),
    .level_o(protect)
  );

  fhd_checksum #(
    .W(WORD_W)
  ) u_checksum (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_i(cks_clear),
    .add_i(cks_add),
    .word_i(cks_word),
    .sum_o(cks_sum)
  );

  // --
  // combinational status
  // --
  assign busy = (state != FHD_IDLE);
  assign word_tick = (tick_cnt == 8'(WORD_CYCLES - 1));
  // skip asked when the named condition holds, i.e. the fault is reset
  assign test_cond = {~flags[EV_PROG], online, ~flags[EV_ROVF], ~flags[EV_WOVF],
                      ~flags[EV_CKSUM], ~protect, ~busy}; // RL2
  assign pi1_o = pi1_en & (flags[EV_PROG] | flags[EV_CKSUM]); // RL7
  assign pi2_o = pi2_en & (flags[EV_ROVF] | flags[EV_WOVF]); // RL7
  assign irq_o = |(flags & irq_en);
  assign host_rd_avail_o = rbuf_full;
  assign host_wr_request_o = busy & dir_write & ~wbuf_full;
  assign disc_write_o = busy & dir_write;
  assign disc_read_o = busy & ~dir_write;
  // the read buffer flag is declared with the other state above

  // --
  // next-state logic for commands, host transfers and the sequencer
  // --
  always_comb begin
    next_state = state;
    next_tick_cnt = tick_cnt;
    next_word_idx = word_idx;
    next_gap_cnt = gap_cnt;
    next_track = disc_track_o;
    next_sector = disc_sector_o;
    next_seq = seq;
    next_dir_write = dir_write;
    next_pi1_en = pi1_en;
    next_pi2_en = pi2_en;
    next_wbuf = wbuf;
    next_wbuf_full = wbuf_full;
    next_rbuf = rbuf;
    next_rbuf_full = rbuf_full;
    next_host_rd_data = host_rd_data_o;
    next_disc_wr_data = disc_wr_data_o;
    next_btc_init = 1'b0;
    next_disc_word = 1'b0;
    cks_clear = 1'b0;
    cks_add = 1'b0;
    cks_word = disc_rd_data_i;
    ev = '0;
    // command word decode
    if (cmd_strobe_i) begin
      if (cmd_word_i[CMD_PI1]) begin
        next_pi1_en = cmd_word_i[CMD_PI_EN]; // RL6 RL5
      end
      if (cmd_word_i[CMD_PI2]) begin
        next_pi2_en = cmd_word_i[CMD_PI_EN]; // RL6 RL5
      end
      // channel init pulse, wired by the host to its channel
      next_btc_init = cmd_word_i[CMD_BTC_A] | cmd_word_i[CMD_BTC_B]; // RL13
      unique case (cmd_word_i[1:0]) // RL1
        CMD_TYPE_SELECT: begin
          if (busy) begin
            ev[EV_PROG] = 1'b1;
          end else begin
            next_track = cmd_word_i[CMD_TRK_HI:CMD_TRK_LO]; // RL8 RL15
          end
        end
        CMD_TYPE_WRITE, CMD_TYPE_READ: begin
          if (busy) begin
            ev[EV_PROG] = 1'b1;
          end else begin
            next_dir_write = (cmd_word_i[1:0] == CMD_TYPE_WRITE); // RL10
            next_seq = cmd_word_i[CMD_SEQ]; // RL9
            next_sector = cmd_word_i[CMD_SEC_HI:CMD_SEC_LO]; // RL9 RL10
            next_state = FHD_WORD;
            next_tick_cnt = '0;
            next_word_idx = '0;
            next_rbuf_full = 1'b0;
            cks_clear = 1'b1;
          end
        end
        default: begin
          // neither bit set: no such command
          ev[EV_PROG] = 1'b1;
        end
      endcase
    end
    // host read transfer: one word per strobe
    if (host_rd_strobe_i) begin
      if (rbuf_full) begin
        next_host_rd_data = rbuf; // RL14
        next_rbuf_full = 1'b0;
      end else begin
        ev[EV_PROG] = 1'b1;
      end
    end
    // host write transfer: one word per strobe
    if (host_wr_strobe_i) begin
      if (busy && dir_write && !wbuf_full) begin
        next_wbuf = host_wr_data_i; // RL14
        next_wbuf_full = 1'b1;
      end else begin
        ev[EV_PROG] = 1'b1;
      end
    end
    // sector sequencer
    unique case (state)
      FHD_IDLE: begin
        next_tick_cnt = '0;
      end
      FHD_WORD, FHD_CKSUM: begin
        next_tick_cnt = word_tick ? 8'h00 : tick_cnt + 8'h01;
        if (word_tick) begin
          next_disc_word = 1'b1;
          if (state == FHD_CKSUM) begin
            if (dir_write) begin
              next_disc_wr_data = cks_sum; // RL16
            end else if (disc_rd_data_i != cks_sum) begin
              ev[EV_CKSUM] = 1'b1; // RL16
            end
            next_state = FHD_GAP;
            next_gap_cnt = '0;
          end else begin
            cks_add = 1'b1;
            if (dir_write) begin
              cks_word = wbuf_full ? wbuf : '0;
              next_disc_wr_data = cks_word;
              next_wbuf_full = 1'b0;
              ev[EV_WOVF] = ~wbuf_full; // RL17
            end else begin
              // host missed the previous word: overwritten
              ev[EV_ROVF] = rbuf_full & ~host_rd_strobe_i; // RL17
              next_rbuf = disc_rd_data_i;
              next_rbuf_full = 1'b1;
            end
            next_word_idx = word_idx + 7'h01;
            if (word_idx == 7'(WORDS_PER_SECTOR - 1)) begin
              next_state = FHD_CKSUM; // RL11
            end
          end
        end
      end
      FHD_GAP: begin
        next_gap_cnt = gap_cnt + 10'h001;
        if (gap_cnt == 10'(GAP_CYCLES - 1)) begin
          // gap over: next sector or done
          if (seq && disc_sector_o != 4'(SECTORS_PER_TRACK - 1)) begin
            next_sector = disc_sector_o + 4'h1; // RL9 RL11
            next_state = FHD_WORD;
            next_word_idx = '0;
            next_tick_cnt = '0;
            cks_clear = 1'b1;
          end else begin
            next_state = FHD_IDLE;
            ev[EV_DONE] = 1'b1;
          end
        end // RL12
      end
      default: begin
        next_state = FHD_IDLE;
      end
    endcase
  end

  // --
  // register port, sticky events, test answer
  // --
  always_comb begin
    next_flags = flags;
    next_irq_en = irq_en;
    next_rdata = 32'h00000000;
    if (reg_we_i && reg_addr_i == REG_CLEAR) begin
      next_flags = flags & ~reg_wdata_i[EV_W-1:0];
    end
    if (reg_we_i && reg_addr_i == REG_ENABLE) begin
      next_irq_en = reg_wdata_i[EV_W-1:0];
    end
    // an event in the clearing cycle is kept
    next_flags = next_flags | ev;
    if (reg_re_i) begin
      unique case (reg_addr_i)
        REG_STATUS: next_rdata = {27'h0000000, flags};
        REG_ENABLE: next_rdata = {27'h0000000, irq_en};
        REG_POSITION: next_rdata = {16'h0000, busy, 2'h0, disc_track_o, disc_sector_o};
        default: next_rdata = 32'h00000000;
      endcase
    end
    // one-hot test word; bits beyond doc bit 6 take no part
    next_skip = |(test_word_i[TEST_HI:TEST_LO] & test_cond); // RL3 RL4
  end

  // --
  // registers
  // --
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= FHD_IDLE;
      tick_cnt <= 8'h00;
      word_idx <= 7'h00;
      gap_cnt <= 10'h000;
      disc_track_o <= 9'h000;
      disc_sector_o <= 4'h0;
      seq <= 1'b0;
      dir_write <= 1'b0;
      pi1_en <= 1'b0;
      pi2_en <= 1'b0;
      wbuf <= 16'h0000;
      wbuf_full <= 1'b0;
      rbuf <= 16'h0000;
      rbuf_full <= 1'b0;
      host_rd_data_o <= 16'h0000;
      disc_wr_data_o <= 16'h0000;
      flags <= EV_RESET;
      irq_en <= EV_RESET;
      reg_rdata_o <= 32'h00000000;
      skip_o <= 1'b0;
      skip_valid_o <= 1'b0;
      btc_init_o <= 1'b0;
      disc_word_o <= 1'b0;
    end else begin
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      word_idx <= next_word_idx;
      gap_cnt <= next_gap_cnt;
      disc_track_o <= next_track;
      disc_sector_o <= next_sector;
      seq <= next_seq;
      dir_write <= next_dir_write;
      pi1_en <= next_pi1_en;
      pi2_en <= next_pi2_en;
      wbuf <= next_wbuf;
      wbuf_full <= next_wbuf_full;
      rbuf <= next_rbuf;
      rbuf_full <= next_rbuf_full;
      host_rd_data_o <= next_host_rd_data;
      disc_wr_data_o <= next_disc_wr_data;
      flags <= next_flags;
      irq_en <= next_irq_en;
      reg_rdata_o <= next_rdata;
      skip_o <= next_skip;
      skip_valid_o <= test_strobe_i;
      btc_init_o <= next_btc_init;
      disc_word_o <= next_disc_word;
    end
  end
endmodule
`default_nettype wire

// ### verilog/fhd_pkg.sv
// shared constants of the fixed-head disc controller
package fhd_pkg;

  // ----------------------------------------------------------------
  // word layout (doc bit n of a host word sits at vector index 15-n)
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W = 16;          // host and disc word width
  localparam int unsigned TRACK_W = 9;          // track number, 512 heads
  localparam int unsigned SECTOR_W = 4;         // 16 sectors per track
  localparam int unsigned CMD_BTC_A = 15;       // block channel init, doc bit 0
  localparam int unsigned CMD_PI_EN = 14;       // enable/disable choice, doc bit 1
  localparam int unsigned CMD_PI1 = 13;         // interrupt one select, doc bit 2
  localparam int unsigned CMD_PI2 = 12;         // interrupt two select, doc bit 3
  localparam int unsigned CMD_SEQ = 11;         // sequential flag, doc bit 4
  localparam int unsigned CMD_TRK_HI = 11;      // track field, doc bits 4..12
  localparam int unsigned CMD_TRK_LO = 3;
  localparam int unsigned CMD_SEC_HI = 6;       // sector field, doc bits 9..12
  localparam int unsigned CMD_SEC_LO = 3;
  localparam int unsigned CMD_BTC_B = 2;        // block channel init, doc bit 13
  localparam logic [1:0] CMD_TYPE_SELECT = 2'h3; // doc bits 14,15 = 1,1
  localparam logic [1:0] CMD_TYPE_WRITE = 2'h2;  // doc bits 14,15 = 1,0
  localparam logic [1:0] CMD_TYPE_READ = 2'h1;   // doc bits 14,15 = 0,1
  localparam int unsigned TEST_HI = 15;          // test bits, doc bits 0..6
  localparam int unsigned TEST_LO = 9;

  // ----------------------------------------------------------------
  // geometry and timing
  // ----------------------------------------------------------------
  localparam int unsigned WORDS_PER_SECTOR = 111;
  localparam int unsigned SECTORS_PER_TRACK = 16;
  localparam int unsigned WORDS_PER_TRACK = WORDS_PER_SECTOR * SECTORS_PER_TRACK; // 1776
  localparam int unsigned CLK_HZ = 20000000;     // 20 MHz system clock
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned WORD_RATE_HZ = 112500; // disc word rate
  localparam int unsigned WORD_CYCLES = CLK_HZ / WORD_RATE_HZ; // 177
  localparam int unsigned GAP_TIME_NS = 37200;   // gap between sectors
  localparam int unsigned GAP_CYCLES = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // 744

  // ----------------------------------------------------------------
  // register map and event bits
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] REG_STATUS = 4'h0;     // sticky events, read only
  localparam logic [3:0] REG_CLEAR = 4'h4;      // write one to clear, write only
  localparam logic [3:0] REG_ENABLE = 4'h8;     // interrupt enables
  localparam logic [3:0] REG_POSITION = 4'hC;   // track, sector, busy, read only
  localparam int unsigned EV_W = 5;
  localparam int unsigned EV_PROG = 0;          // program error
  localparam int unsigned EV_CKSUM = 1;         // checksum error
  localparam int unsigned EV_ROVF = 2;          // read overflow
  localparam int unsigned EV_WOVF = 3;          // write overflow
  localparam int unsigned EV_DONE = 4;          // transfer finished
  localparam logic [4:0] EV_RESET = 5'h00;

  // transfer sequencer states
  typedef enum logic [1:0] {
    FHD_IDLE = 2'b00,
    FHD_WORD = 2'b01,
    FHD_CKSUM = 2'b10,
    FHD_GAP = 2'b11
  } fhd_state_e;

endpackage

// ### verilog/fhd_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module fhd_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // pin and clean level
  input wire logic pin_i,
  output logic level_o
);
  logic s1, s2, s3;   // stage flops; s1 feeds only s2
  logic next_level;   // filtered level

  // ----------------------------------------------------------------
  // level follows once stage two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    next_level = level_o;
    if (s2 == s3) begin
      next_level = s3;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      level_o <= next_level;
    end
  end
endmodule
`default_nettype wire
